// ===== hw/tuc_pkg.sv
// package for the timer unit enable, start and output control slice
package tuc_pkg;
  localparam logic [19:0] ADDR_CLOCK_ENABLE = 20'hF00F0;
  localparam logic [19:0] ADDR_OUT_UNIT0 = 20'hF01B8;
  localparam logic [19:0] ADDR_OUT_UNIT1 = 20'hF01E0;
  localparam logic [19:0] ADDR_CTRL_UNIT0 = 20'hF0200;
  localparam logic [19:0] ADDR_CTRL_UNIT1 = 20'hF0240;
  localparam int CTRL_STRIDE = 4;
  localparam logic [19:0] CTRL_OFS_START = 20'h00000;
  localparam logic [19:0] CTRL_OFS_STOP = 20'h00001;
  localparam logic [19:0] CTRL_OFS_OUT_EN = 20'h00002;
  localparam logic [19:0] CTRL_OFS_CH_BASE = 20'h00010;
  localparam logic [7:0] CLOCK_ENABLE_RESET = 8'h00;
  localparam logic [15:0] OUT_RESET = 16'h0000;
  localparam int UNIT0_EN_BIT = 0;
  localparam int UNIT1_EN_BIT = 1;
  localparam int UNIT0_CHANNELS = 8;
  localparam int UNIT1_CHANNELS = 4;
  localparam int NUM_CH = 12;
  localparam logic [15:0] UNIT0_OUT_MASK = 16'h00FF;
  localparam logic [15:0] UNIT1_OUT_MASK = 16'h000F;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {TUC_MODE_INTERVAL, TUC_MODE_ONE_COUNT, TUC_MODE_CAPTURE_ONE}
    tuc_mode_t;
  typedef enum {TUC_IDLE, TUC_WAIT_TRIG, TUC_WAIT_CLK, TUC_COUNT} tuc_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic bit_op;
    logic [3:0] bit_sel;
  } tuc_bus_t;
endpackage

// ===== hw/tuc_top.sv
// timer unit control slice: clock enable, channel start and output buffer
`timescale 1ns/100ps

module tuc_top (
  input wire logic clk,
  input wire logic rst,
  input tuc_pkg::tuc_bus_t bus,
  output logic [15:0] rdata,
  input wire logic [1:0] count_clock,
  input wire logic [tuc_pkg::NUM_CH-1:0] trigger,
  input wire logic [tuc_pkg::NUM_CH-1:0] timer_out_next,
  input wire logic [tuc_pkg::NUM_CH-1:0] timer_out_update,
  output logic [7:0] peripheral_clock_gate,
  output logic [1:0] unit_reset,
  output logic [tuc_pkg::NUM_CH-1:0] timer_out_pin,
  output logic [tuc_pkg::NUM_CH-1:0] channel_enabled_status,
  output logic [tuc_pkg::NUM_CH-1:0] start_interrupt,
  output logic [tuc_pkg::NUM_CH*16-1:0] channel_count_reg
);
  import tuc_pkg::*;

  // register map seen from the cpu bus
  // enable register: one byte, bit or byte writes
  // enable bit 0 gates timer unit 0
  // enable bit 1 gates timer unit 1
  // upper enable bits only mirrored to the gate port
  // output register unit 0: eight live bits
  // output register unit 0: upper byte reads zero
  // output register unit 1: four live bits
  // output register unit 1: upper bits read zero
  // low lane alone writes the low byte alias
  // both lanes write the full word
  // control window unit 0 sits below unit 1
  // control window unit 1 spans sixty-four bytes
  // window offset 0: start bits, one per channel
  // window offset 0 read: enabled status bits
  // window offset 1: stop bits, one per channel
  // window offset 2: output enable bits
  // per channel config at base plus four per channel
  // config bit 0: start interrupt mode
  // config bits 2:1: operating mode
  // mode 0 interval, 1 one-count, 2 capture one-count
  // per channel data word two bytes above config
  // unit 1 channel bits sit in the low nibble

  // behaviour when a unit is switched off
  // every channel state returns to idle
  // counters return to zero
  // enabled status bits drop
  // config, data and output enables clear
  // output buffer bits clear, pins go low
  // control writes are dropped
  // control reads return zero

  // channel start sequencing
  // start bit only acts on an idle channel
  // interval: waits for the next count clock
  // one-count: waits for a trigger first
  // capture one-count: waits for a trigger first
  // first count clock loads the start value
  // interval and one-count load the data word
  // capture one-count loads zero
  // start interrupt pulses one cycle at that load
  // later count clocks step the counter
  // interval reloads the data word at zero
  // one-count rearms for a trigger at zero
  // stop bit returns a channel to idle

  // timing seen from the bus
  // writes land on the edge that samples them
  // read data is registered, valid one cycle later
  // read data returns zero when no read is made
  // back to back accesses are accepted

  // hazards worth knowing
  // count clocks are one-cycle enables, not clocks
  // start may lag the write by one count clock
  // output enable hands a pin to the timer side
  // software must clear a pin bit before port use
  // the gate port is a level, not a clock

  logic [7:0] peripheral_clock_enable;
  logic [15:0] timer_output_unit0;
  logic [15:0] timer_output_unit1;
  logic [NUM_CH-1:0] channel_output_enable;
  logic [NUM_CH-1:0] start_interrupt_mode_bit;
  logic [NUM_CH*2-1:0] ch_mode;
  logic [NUM_CH*16-1:0] channel_data_reg;
  logic [1:0] unit_on;
  logic [NUM_CH-1:0] ch_unit_on;
  logic [NUM_CH-1:0] ch_clk;
  logic [NUM_CH-1:0] start_wr;
  logic [NUM_CH-1:0] stop_wr;
  logic [NUM_CH-1:0] cfg_wr;
  logic [NUM_CH-1:0] data_wr;
  logic [NUM_CH-1:0] oe_word;
  logic [NUM_CH-1:0] ch_sel;
  logic [NUM_CH-1:0] out_flat;
  logic ctrl0_hit;
  logic ctrl1_hit;
  logic [19:0] ctrl_ofs;
  logic [15:0] chan_word;

  // per-unit enable and held reset
  assign unit_on[0] = peripheral_clock_enable[UNIT0_EN_BIT];
  assign unit_on[1] = peripheral_clock_enable[UNIT1_EN_BIT];
  assign peripheral_clock_gate = peripheral_clock_enable;
  assign unit_reset = ~unit_on;

  // enable register, bit or byte write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peripheral_clock_enable <= CLOCK_ENABLE_RESET;
    end else if (bus.wr && bus.addr == ADDR_CLOCK_ENABLE) begin
      if (bus.bit_op) begin
        peripheral_clock_enable[bus.bit_sel[2:0]] <= bus.wdata[0];
      end else if (bus.be[0]) begin
        peripheral_clock_enable <= bus.wdata[7:0];
      end
    end
  end

  // control window decode per unit
  assign ctrl0_hit = bus.addr >= ADDR_CTRL_UNIT0 && bus.addr < ADDR_CTRL_UNIT1;
  assign ctrl1_hit = bus.addr >= ADDR_CTRL_UNIT1 && bus.addr < ADDR_CTRL_UNIT1 + 20'h00040;
  assign ctrl_ofs = ctrl1_hit ? bus.addr - ADDR_CTRL_UNIT1 : bus.addr - ADDR_CTRL_UNIT0;
  assign chan_word = ctrl1_hit ? {bus.wdata[11:0], 4'h0} : bus.wdata;

  // channel-level decode and start state machine
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      localparam int U = (g < UNIT0_CHANNELS) ? 0 : 1;
      localparam int LC = (g < UNIT0_CHANNELS) ? g : g - UNIT0_CHANNELS;
      localparam logic [19:0] CH_OFS = CTRL_OFS_CH_BASE + 20'(LC * CTRL_STRIDE);
      tuc_state_t state;
      logic [15:0] cnt;
      logic hit;
      logic bitw;

      assign ch_unit_on[g] = unit_on[U];
      assign ch_clk[g] = count_clock[U];
      assign hit = bus.wr && ch_unit_on[g] && ((U == 0) ? ctrl0_hit : ctrl1_hit);
      assign bitw = chan_word[(U == 0) ? LC : LC + 4];
      assign start_wr[g] = hit && ctrl_ofs == CTRL_OFS_START && bitw;
      assign stop_wr[g] = hit && ctrl_ofs == CTRL_OFS_STOP && bitw;
      assign oe_word[g] = bitw;
      assign cfg_wr[g] = hit && ctrl_ofs == CH_OFS;
      assign data_wr[g] = hit && ctrl_ofs == CH_OFS + 20'h00002;
      assign ch_sel[g] = (bus.addr == ((U == 0) ? ADDR_CTRL_UNIT0 : ADDR_CTRL_UNIT1) + CH_OFS);
      assign channel_count_reg[g*16 +: 16] = cnt;

      // channel mode and data registers
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ch_mode[g*2 +: 2] <= 2'h0;
          start_interrupt_mode_bit[g] <= 1'b0;
          channel_data_reg[g*16 +: 16] <= 16'h0000;
        end else if (!ch_unit_on[g]) begin
          ch_mode[g*2 +: 2] <= 2'h0;
          start_interrupt_mode_bit[g] <= 1'b0;
          channel_data_reg[g*16 +: 16] <= 16'h0000;
        end else if (cfg_wr[g]) begin
          ch_mode[g*2 +: 2] <= bus.wdata[2:1];
          start_interrupt_mode_bit[g] <= bus.wdata[0];
        end else if (data_wr[g]) begin
          channel_data_reg[g*16 +: 16] <= bus.wdata;
        end
      end

      // start sequencing and counting
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          state <= TUC_IDLE;
          cnt <= COUNT_ZERO;
          channel_enabled_status[g] <= 1'b0;
          start_interrupt[g] <= 1'b0;
        end else if (!ch_unit_on[g] || stop_wr[g]) begin
          state <= TUC_IDLE;
          cnt <= COUNT_ZERO;
          channel_enabled_status[g] <= 1'b0;
          start_interrupt[g] <= 1'b0;
        end else begin
          start_interrupt[g] <= 1'b0;
          case (state)
            TUC_IDLE: begin
              if (start_wr[g]) begin
                channel_enabled_status[g] <= 1'b1;
                if (tuc_mode_t'(ch_mode[g*2 +: 2]) == TUC_MODE_INTERVAL) begin
                  state <= TUC_WAIT_CLK;
                end else begin
                  state <= TUC_WAIT_TRIG;
                end
              end
            end
            TUC_WAIT_TRIG: begin
              if (trigger[g]) begin
                state <= TUC_WAIT_CLK;
              end
            end
            TUC_WAIT_CLK: begin
              if (ch_clk[g]) begin
                state <= TUC_COUNT;
                start_interrupt[g] <= start_interrupt_mode_bit[g];
                if (tuc_mode_t'(ch_mode[g*2 +: 2]) == TUC_MODE_CAPTURE_ONE) begin
                  cnt <= COUNT_ZERO;
                end else begin
                  cnt <= channel_data_reg[g*16 +: 16];
                end
              end
            end
            TUC_COUNT: begin
              if (ch_clk[g]) begin
                if (tuc_mode_t'(ch_mode[g*2 +: 2]) == TUC_MODE_CAPTURE_ONE) begin
                  cnt <= cnt + 16'h0001;
                end else if (cnt == COUNT_ZERO &&
                    tuc_mode_t'(ch_mode[g*2 +: 2]) == TUC_MODE_INTERVAL) begin
                  cnt <= channel_data_reg[g*16 +: 16];
                  start_interrupt[g] <= 1'b0;
                end else if (cnt == COUNT_ZERO) begin
                  state <= TUC_WAIT_TRIG;
                end else begin
                  cnt <= cnt - 16'h0001;
                end
              end
            end
            default: begin
              state <= TUC_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  // output enable register per unit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_output_enable <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!ch_unit_on[i]) begin
          channel_output_enable[i] <= 1'b0;
        end else if (bus.wr && ctrl_ofs == CTRL_OFS_OUT_EN &&
            ((i < UNIT0_CHANNELS) ? ctrl0_hit : ctrl1_hit)) begin
          channel_output_enable[i] <= oe_word[i];
        end
      end
    end
  end

  // timer output buffer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_output_unit0 <= OUT_RESET;
      timer_output_unit1 <= OUT_RESET;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (i < UNIT0_CHANNELS) begin
          if (!unit_on[0]) begin
            timer_output_unit0[i] <= 1'b0;
          end else if (channel_output_enable[i]) begin
            if (timer_out_update[i]) begin
              timer_output_unit0[i] <= timer_out_next[i];
            end
          end else if (bus.wr && bus.addr == ADDR_OUT_UNIT0 && bus.be[0]) begin
            timer_output_unit0[i] <= bus.wdata[i];
          end
        end else begin
          if (!unit_on[1]) begin
            timer_output_unit1[i - UNIT0_CHANNELS] <= 1'b0;
          end else if (channel_output_enable[i]) begin
            if (timer_out_update[i]) begin
              timer_output_unit1[i - UNIT0_CHANNELS] <= timer_out_next[i];
            end
          end else if (bus.wr && bus.addr == ADDR_OUT_UNIT1 && bus.be[0]) begin
            timer_output_unit1[i - UNIT0_CHANNELS] <= bus.wdata[i - UNIT0_CHANNELS];
          end
        end
      end
      timer_output_unit0[15:8] <= 8'h00;
      timer_output_unit1[15:4] <= 12'h000;
    end
  end

  // pins follow the buffer bits
  assign out_flat = {timer_output_unit1[3:0], timer_output_unit0[7:0]};
  assign timer_out_pin = out_flat;

  // read data, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (!bus.rd) begin
      rdata <= 16'h0000;
    end else if (bus.addr == ADDR_CLOCK_ENABLE) begin
      rdata <= {8'h00, peripheral_clock_enable};
    end else if (bus.addr == ADDR_OUT_UNIT0) begin
      rdata <= unit_on[0] ? (timer_output_unit0 & UNIT0_OUT_MASK) : OUT_RESET;
    end else if (bus.addr == ADDR_OUT_UNIT1) begin
      rdata <= unit_on[1] ? (timer_output_unit1 & UNIT1_OUT_MASK) : OUT_RESET;
    end else if (ctrl0_hit && ctrl_ofs == CTRL_OFS_START) begin
      rdata <= unit_on[0] ? {8'h00, channel_enabled_status[7:0]} : 16'h0000;
    end else if (ctrl1_hit && ctrl_ofs == CTRL_OFS_START) begin
      rdata <= unit_on[1] ? {12'h000, channel_enabled_status[11:8]} : 16'h0000;
    end else begin
      rdata <= 16'h0000;
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_sel[i] && ch_unit_on[i]) begin
          rdata <= {13'h0000, ch_mode[i*2 +: 2], start_interrupt_mode_bit[i]};
        end
      end
    end
  end
endmodule // tuc_top

// ===== verification/tb_top.sv
// self-checking bench for the timer unit control slice
`timescale 1ns/100ps
module tb_top;
  import tuc_pkg::*;
  localparam logic [15:0] CFG [0:2] = '{16'h0001, 16'h0002, 16'h0004};
  localparam logic [15:0] E1 [0:2] = '{16'h0005, 16'h0000, 16'h0000};
  localparam logic [15:0] E2 [0:2] = '{16'h0004, 16'h0005, 16'h0000};
  localparam logic [15:0] E3 [0:2] = '{16'h0003, 16'h0004, 16'h0001};
  logic clk, rst;
  tuc_bus_t bus;
  logic [15:0] rdata;
  logic [1:0] count_clock, ureset;
  logic [NUM_CH-1:0] trigger, nxt, upd, pin, stat, irq, irq_seen;
  logic [7:0] gate;
  logic [NUM_CH*16-1:0] cnt;
  int mismatches, checked;
  tuc_top dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .count_clock(count_clock),
    .trigger(trigger), .timer_out_next(nxt), .timer_out_update(upd),
    .peripheral_clock_gate(gate), .unit_reset(ureset), .timer_out_pin(pin),
    .channel_enabled_status(stat), .start_interrupt(irq), .channel_count_reg(cnt));
  // clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // latch start interrupt pulses so none is missed
  always @(posedge clk) irq_seen <= rst ? '0 : (irq_seen | irq);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic [1:0] be);
    bus = {1'b1, 1'b0, a, d, be, 1'b0, 4'h0};
    cyc(1);
    bus = '0;
    cyc(1);
  endtask
  task automatic bwr(input logic [3:0] b, input logic v);
    bus = {1'b1, 1'b0, ADDR_CLOCK_ENABLE, 15'h0, v, 2'b01, 1'b1, b};
    cyc(1);
    bus = '0;
    cyc(1);
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] exp, input string what);
    bus = {1'b0, 1'b1, a, 16'h0, 2'b11, 1'b0, 4'h0};
    cyc(1);
    bus = '0;
    check(what, rdata, exp);
  endtask
  task automatic pulse(input logic [1:0] c, input logic [NUM_CH-1:0] t);
    count_clock = c;
    trigger = t;
    cyc(1);
    count_clock = '0;
    trigger = '0;
    cyc(2);
  endtask
  // watchdog against a hung run
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
  // main test sequence
  initial begin
    bus = '0; count_clock = '0; trigger = '0; nxt = '0; upd = '0; rst = 1'b1;
    mismatches = 0; checked = 0;
    cyc(4);
    rst = 1'b0;
    cyc(1);
    check("gate", {8'h00, gate}, 16'h0000);
    check("unit_reset", {14'h0, ureset}, 16'h0003);
    rd(ADDR_CLOCK_ENABLE, 16'h0000, "enable reg");
    wr(ADDR_OUT_UNIT0, 16'h00FF, 2'b11);
    rd(ADDR_OUT_UNIT0, 16'h0000, "out0 disabled");
    bwr(4'h0, 1'b1);
    check("unit_reset bit", {14'h0, ureset}, 16'h0002);
    wr(ADDR_CLOCK_ENABLE, 16'h0003, 2'b01);
    check("gate byte", {8'h00, gate}, 16'h0003);
    wr(ADDR_OUT_UNIT0, 16'hFFFF, 2'b11);
    wr(ADDR_OUT_UNIT1, 16'hFFFF, 2'b11);
    check("pins", {4'h0, pin}, 16'h0FFF);
    rd(ADDR_OUT_UNIT0, 16'h00FF, "out0");
    rd(ADDR_OUT_UNIT1, 16'h000F, "out1");
    wr(ADDR_OUT_UNIT0, 16'h1255, 2'b01);
    rd(ADDR_OUT_UNIT0, 16'h0055, "out0 low byte");
    wr(ADDR_CTRL_UNIT0 + CTRL_OFS_OUT_EN, 16'h0001, 2'b11);
    wr(ADDR_OUT_UNIT0, 16'h0000, 2'b11);
    check("pins held", {4'h0, pin}, 16'h0F01);
    upd = 12'h001;
    cyc(1);
    upd = '0;
    cyc(1);
    check("pins timer", {4'h0, pin}, 16'h0F00);
    // channels 1..3 in interval, one-count and capture one-count
    for (int ch = 1; ch < 4; ch++) begin
      wr(ADDR_CTRL_UNIT0 + CTRL_OFS_CH_BASE + 20'(4 * ch), CFG[ch-1], 2'b11);
      wr(ADDR_CTRL_UNIT0 + CTRL_OFS_CH_BASE + 20'(4 * ch + 2), 16'h0005, 2'b11);
      wr(ADDR_CTRL_UNIT0 + CTRL_OFS_START, 16'(1 << ch), 2'b11);
      check("status", {4'h0, stat}, 16'((2 << ch) - 2));
      check("count idle", cnt[ch*16 +: 16], 16'h0000);
      pulse(2'b01, '0);
      check("count first", cnt[ch*16 +: 16], E1[ch-1]);
      pulse(2'b00, 12'(1 << ch));
      check("count trig", cnt[ch*16 +: 16], E1[ch-1]);
      pulse(2'b01, '0);
      check("count load", cnt[ch*16 +: 16], E2[ch-1]);
      pulse(2'b01, '0);
      check("count step", cnt[ch*16 +: 16], E3[ch-1]);
    end
    check("irq", {4'h0, irq_seen}, 16'h0002);
    wr(ADDR_CTRL_UNIT0 + CTRL_OFS_STOP, 16'h0004, 2'b11);
    check("count stopped", cnt[47:32], 16'h0000);
    check("status stopped", {4'h0, stat}, 16'h000A);
    wr(ADDR_CLOCK_ENABLE, 16'h0002, 2'b01);
    check("count disabled", cnt[31:16], 16'h0000);
    rd(ADDR_CTRL_UNIT0 + CTRL_OFS_START, 16'h0000, "status disabled");
    finish_test();
  end
endmodule // tb_top

// ===== verification/tuc_props.sv
// port assertions for the timer unit control slice
`timescale 1ns/100ps
module tuc_checker
  import tuc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input tuc_pkg::tuc_bus_t bus,
  input wire logic [15:0] rdata,
  input wire logic [1:0] count_clock,
  input wire logic [tuc_pkg::NUM_CH-1:0] timer_out_update,
  input wire logic [7:0] peripheral_clock_gate,
  input wire logic [1:0] unit_reset,
  input wire logic [tuc_pkg::NUM_CH-1:0] timer_out_pin,
  input wire logic [tuc_pkg::NUM_CH-1:0] channel_enabled_status,
  input wire logic [tuc_pkg::NUM_CH-1:0] start_interrupt,
  input wire logic [tuc_pkg::NUM_CH*16-1:0] channel_count_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // enable register, unit reset and output register
  chk_gate_unit0: assert property (unit_reset[0] == !peripheral_clock_gate[UNIT0_EN_BIT])
    else $error("unit0 reset disagrees with its enable bit");
  chk_reset_clear: assert property ($fell(rst) |-> peripheral_clock_gate == 8'h00)
    else $error("enable register not clear after reset");
  chk_unit_held: assert property (unit_reset[0] |=> channel_enabled_status[7:0] == 8'h00)
    else $error("disabled unit0 still shows running channels");
  chk_out0_upper: assert property (bus.rd && bus.addr == ADDR_OUT_UNIT0 |=> rdata[15:8] == 8'h00)
    else $error("unit0 output upper byte not zero");
  chk_out1_upper: assert property (bus.rd && bus.addr == ADDR_OUT_UNIT1 |=> rdata[15:4] == 12'h000)
    else $error("unit1 output upper bits not zero");
  chk_pin_cause: assert property ($changed(timer_out_pin) |-> $past(bus.wr) ||
    $past(timer_out_update) != '0 || $past(unit_reset) != '0)
    else $error("output pin changed with no write or timer update");
  // channel start and counting
  chk_irq_pulse: assert property (start_interrupt != '0 |=> (start_interrupt & $past(start_interrupt)) == '0)
    else $error("start interrupt longer than one cycle");
  chk_irq_running: assert property ((start_interrupt & ~channel_enabled_status) == '0)
    else $error("start interrupt from a channel not enabled");
  chk_count_idle: assert property ((!bus.wr && count_clock == 2'b00) [*2] |=> $stable(channel_count_reg))
    else $error("counter moved with no count clock");
  chk_start_sets: assert property (bus.wr && bus.be[0] && bus.addr == ADDR_CTRL_UNIT0 && !unit_reset[0]
    |=> (~channel_enabled_status[7:0] & $past(bus.wdata[7:0])) == 8'h00)
    else $error("start write did not set enabled status");
  cover property (start_interrupt != '0);
  cover property (bus.wr && bus.bit_op);
  cover property ($rose(unit_reset[0]));
endmodule // tuc_checker

bind tuc_top tuc_checker chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .count_clock(count_clock), .timer_out_update(timer_out_update),
  .peripheral_clock_gate(peripheral_clock_gate), .unit_reset(unit_reset),
  .timer_out_pin(timer_out_pin), .channel_enabled_status(channel_enabled_status),
  .start_interrupt(start_interrupt), .channel_count_reg(channel_count_reg));
